/* fepc_arm_flag.v */
// Sticky one-bit arm flag: set by a prerequisite write, consumed by its trigger
`timescale 1ns/1ps
`default_nettype none
module fepc_arm_flag (
   input  wire core_clk,
   input  wire resetn,
   input  wire clk_en,
   input  wire set_i,
   input  wire consume_i,
   output wire armed
);
   reg arm_reg;
   reg arm_next;
   always @* begin
      arm_next = arm_reg;
      if (consume_i)
         arm_next = 1'b0;
      // A fresh write in the consuming cycle re-arms
      if (set_i)
         arm_next = 1'b1;
   end
   always @(posedge core_clk) begin
      if (!resetn)
         arm_reg <= 1'b0;
      else if (clk_en)
         arm_reg <= arm_next;
   end
   assign armed = arm_reg;
endmodule
`default_nettype wire

/* fepc_ctrl.v */
// Flash erase/program controller on the special function register port
// Function
// - 0x55 trigger starts page erase after address
// - 0xAA starts mass erase if enabled, debug
// - Other trigger values ignored; trigger resets zero
// - Mass erase enable bit 1, reset zero
// - Seven-bit page address in bits 7:1
// - Program write enable steers stores into flash
// - Write enable self-clears after each byte
// - Write enable locked while interrupts enabled
`timescale 1ns/1ps
`default_nettype none
`include "fepc_map.vh"
module fepc_ctrl (
   input  wire       core_clk,
   input  wire       resetn,
   input  wire       clk_en,
   input  wire [7:0] sfr_addr,
   input  wire [7:0] sfr_wdata,
   input  wire       sfr_wr,
   input  wire       sfr_rd,
   output reg  [7:0] sfr_rdata,
   input  wire       irq_global_en,
   input  wire       debug_port_en,
   input  wire       external_data_move_wr,
   input  wire [15:0] data_pointer,
   input  wire [7:0] acc_data,
   input  wire       flash_busy,
   output wire       xram_wr,
   output reg        flash_prog_req,
   output reg [15:0] flash_prog_addr,
   output reg  [7:0] flash_prog_data,
   output reg        page_erase_req,
   output reg        mass_erase_req,
   output reg  [6:0] page_erase_address,
   output wire       erase_active
);
   // =====================================================
   // State
   // =====================================================
   localparam [2:0] ST_IDLE  = 3'b001;
   localparam [2:0] ST_PAGE  = 3'b010;
   localparam [2:0] ST_MASS  = 3'b100;

   reg [2:0] state_reg;
   reg [2:0] state_next;
   reg [7:0] erase_trigger_reg;
   reg       mass_erase_enable_reg;
   reg       program_write_enable_reg;
   reg       flash_wait_reg;

   wire       wr_trig;
   wire       wr_en;
   wire       wr_pg;
   wire       idle;
   wire       page_armed;
   wire       mass_armed;
   wire       key_page;
   wire       key_mass;
   wire       go_page;
   wire       go_mass;
   wire       byte_prog;

   // Decode of the three register writes
   assign wr_trig   = sfr_wr && (sfr_addr == `FEPC_OFS_ERASE_TRIGGER);
   assign wr_en     = sfr_wr && (sfr_addr == `FEPC_OFS_ENABLES);
   assign wr_pg     = sfr_wr && (sfr_addr == `FEPC_OFS_PAGE_ADDR);
   assign idle      = (state_reg == ST_IDLE);
   assign key_page  = wr_trig && (sfr_wdata == `FEPC_KEY_PAGE_ERASE);
   assign key_mass  = wr_trig && (sfr_wdata == `FEPC_KEY_MASS_ERASE);
   // Keys are refused while busy so a running erase is never re-aimed
   assign go_page   = key_page && page_armed && idle;
   assign go_mass   = key_mass && mass_armed && mass_erase_enable_reg && debug_port_en && idle;
   assign byte_prog = program_write_enable_reg && external_data_move_wr;

   // =====================================================
   // Prerequisite tracking
   // =====================================================
   // Each erase key consumes its own arm, so a stale write never carries over
   fepc_arm_flag u_page_arm (
      .core_clk  (core_clk),
      .resetn    (resetn),
      .clk_en    (clk_en),
      .set_i     (wr_pg),
      .consume_i (key_page),
      .armed     (page_armed)
   );
   fepc_arm_flag u_mass_arm (
      .core_clk  (core_clk),
      .resetn    (resetn),
      .clk_en    (clk_en),
      .set_i     (wr_en && sfr_wdata[`FEPC_BIT_MASS_EN]),
      .consume_i (key_mass),
      .armed     (mass_armed)
   );

   // =====================================================
   // Registers
   // =====================================================
   // Write-only trigger; held only so its reset value is defined
   always @(posedge core_clk) begin
      if (!resetn) begin
         erase_trigger_reg <= `FEPC_RST_BYTE;
      end else if (clk_en) begin
         if (wr_trig)
            erase_trigger_reg <= sfr_wdata;
      end
   end

   // Mass erase permission; spent by the erase it allows
   always @(posedge core_clk) begin
      if (!resetn) begin
         mass_erase_enable_reg <= 1'b0;
      end else if (clk_en) begin
         if (wr_en)
            mass_erase_enable_reg <= sfr_wdata[`FEPC_BIT_MASS_EN];
         else if (go_mass)
            mass_erase_enable_reg <= 1'b0;
      end
   end

   // Page to erase, taken from the upper seven bits of the write
   always @(posedge core_clk) begin
      if (!resetn) begin
         page_erase_address <= `FEPC_RST_PAGE;
      end else if (clk_en) begin
         if (wr_pg)
            page_erase_address <= sfr_wdata[`FEPC_PGADR_MSB:`FEPC_PGADR_LSB];
      end
   end

   // Store consumes the enable; a simultaneous write cannot re-set it
   always @(posedge core_clk) begin
      if (!resetn) begin
         program_write_enable_reg <= 1'b0;
      end else if (clk_en) begin
         if (byte_prog)
            program_write_enable_reg <= 1'b0;
         else if (wr_en && !irq_global_en)
            program_write_enable_reg <= sfr_wdata[`FEPC_BIT_PWE];
      end
   end

   // =====================================================
   // Erase sequencer
   // =====================================================
   always @* begin
      state_next = state_reg;
      case (state_reg)
         ST_IDLE: begin
            if (go_page)
               state_next = ST_PAGE;
            else if (go_mass)
               state_next = ST_MASS;
         end
         ST_PAGE: begin
            if (flash_wait_reg && !flash_busy)
               state_next = ST_IDLE;
         end
         ST_MASS: begin
            if (flash_wait_reg && !flash_busy)
               state_next = ST_IDLE;
         end
         default: state_next = ST_IDLE;
      endcase
   end

   always @(posedge core_clk) begin
      if (!resetn) begin
         state_reg      <= ST_IDLE;
         flash_wait_reg <= 1'b0;
      end else if (clk_en) begin
         state_reg      <= state_next;
         // Wait one cycle for the array to raise busy before watching it
         flash_wait_reg <= !idle;
      end
   end

   // One-cycle erase requests to the array
   always @(posedge core_clk) begin
      if (!resetn) begin
         page_erase_req <= 1'b0;
         mass_erase_req <= 1'b0;
      end else if (clk_en) begin
         page_erase_req <= go_page;
         mass_erase_req <= go_mass;
      end
   end

   // Byte program request; address and data hold until the next store into flash
   always @(posedge core_clk) begin
      if (!resetn) begin
         flash_prog_req  <= 1'b0;
         flash_prog_addr <= 16'h0000;
         flash_prog_data <= 8'h00;
      end else if (clk_en) begin
         flash_prog_req <= byte_prog;
         if (byte_prog) begin
            flash_prog_addr <= data_pointer;
            flash_prog_data <= acc_data;
         end
      end
   end

   // Only the write enable is readable; write-only fields read zero
   always @(posedge core_clk) begin
      if (!resetn) begin
         sfr_rdata <= 8'h00;
      end else if (clk_en) begin
         if (sfr_rd && sfr_addr == `FEPC_OFS_ENABLES)
            sfr_rdata <= {7'h00, program_write_enable_reg};
         else
            sfr_rdata <= 8'h00;
      end
   end

   // Stores fall through to data RAM unless the enable is set
   assign xram_wr      = external_data_move_wr && !program_write_enable_reg;
   assign erase_active = !idle;
endmodule
`default_nettype wire

/* fepc_ctrl_properties.sv */
// Controller assertions
`timescale 1ns/1ps
`default_nettype none
module fepc_ctrl_properties (input wire logic core_clk, resetn, sfr_wr, external_data_move_wr, xram_wr,
   flash_prog_req, page_erase_req, mass_erase_req, erase_active, input wire logic [7:0] sfr_addr, sfr_wdata,
   input wire logic [6:0] page_erase_address);
   wire wk = sfr_wr && sfr_addr == 8'h94;
   wire pe = page_erase_req;
   wire me = mass_erase_req;
   wire mv = external_data_move_wr;
   default clocking @(posedge core_clk); endclocking
   default disable iff (!resetn);
   sequence s_run; erase_active ##1 erase_active && !(pe | me); endsequence
   property p_adr; sfr_wr && sfr_addr == 8'hb7 |=> page_erase_address == $past(sfr_wdata[7:1]); endproperty
   a_adr: assert property (p_adr) else $error("page address");
   property p_pg; pe |-> $past(wk && sfr_wdata == 8'h55); endproperty
   a_pg: assert property (p_pg) else $error("page key");
   property p_ms; me |-> $past(wk && sfr_wdata == 8'haa); endproperty
   a_ms: assert property (p_ms) else $error("mass key");
   property p_oth; wk && sfr_wdata[0] == sfr_wdata[1] |=> !(pe | me); endproperty
   a_oth: assert property (p_oth) else $error("bad key");
   property p_run; pe | me |-> s_run; endproperty
   a_run: assert property (p_run) else $error("erase start");
   property p_prg; flash_prog_req |-> $past(mv && !xram_wr); endproperty
   a_prg: assert property (p_prg) else $error("program");
   property p_clr; flash_prog_req ##1 mv && !$past(sfr_wr) |-> xram_wr; endproperty
   a_clr: assert property (p_clr) else $error("no clear");
   property p_xr; mv && xram_wr |=> !flash_prog_req; endproperty
   a_xr: assert property (p_xr) else $error("ram store");
endmodule
bind fepc_ctrl fepc_ctrl_properties u_props (.*);
`default_nettype wire

/* fepc_ctrl_tb_top.sv */
// Controller testbench
`timescale 1ns/1ps
`default_nettype none
module fepc_ctrl_tb_top;
   logic core_clk = 1'h0, resetn = 1'h0, sfr_wr = 1'h0, sfr_rd = 1'h0, irq_global_en = 1'h0;
   logic debug_port_en = 1'h0, external_data_move_wr = 1'h0, flash_busy, xram_wr, flash_prog_req;
   logic page_erase_req, mass_erase_req, erase_active;
   logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, sfr_rdata, flash_prog_data;
   logic [15:0] flash_prog_addr;
   logic [6:0] page_erase_address;
   int fails = 0, check_count = 0;
   always #25 core_clk = ~core_clk;
   fepc_ctrl dut (.*, .clk_en(1'h1), .data_pointer({sfr_wdata, sfr_addr}), .acc_data(~sfr_wdata));
   fepc_flash_model u_fl (.core_clk, .erase_req(page_erase_req | mass_erase_req), .flash_busy);
   task automatic chk(input logic [31:0] g, e);
      check_count++;
      if (g !== e) fails++;
      if (g !== e) $display("unexpected at %0t: got %h", $time, g);
   endtask
   task automatic cyc(input logic [4:0] k, input logic [7:0] x, y);
      @(posedge core_clk) {debug_port_en, irq_global_en, external_data_move_wr, sfr_rd, sfr_wr} <= k;
      {sfr_addr, sfr_wdata} <= {x, y};
      @(posedge core_clk) {external_data_move_wr, sfr_rd, sfr_wr} <= 3'h0;
      #1;
   endtask
   task automatic stop_test;
      $display("%0d checks, %0d fails", check_count, fails);
      if (fails == 0 && check_count > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic t_page;
      cyc(5'h01, 8'hb7, 8'h0a);
      cyc(5'h01, 8'h94, 8'h55);
      chk({page_erase_address, page_erase_req, mass_erase_req, erase_active}, 32'h2d);
      wait (erase_active !== 1'h1);
      cyc(5'h01, 8'h94, 8'h33);
      cyc(5'h01, 8'h94, 8'h55);
      chk({page_erase_req, erase_active}, 32'h0);
      $display("page done");
   endtask
   task automatic t_mass;
      cyc(5'h01, 8'hb2, 8'h02);
      cyc(5'h01, 8'h94, 8'haa);
      chk(mass_erase_req, 32'h0);
      cyc(5'h11, 8'hb2, 8'h02);
      cyc(5'h11, 8'h94, 8'haa);
      chk({mass_erase_req, erase_active}, 32'h3);
      wait (erase_active !== 1'h1);
      cyc(5'h11, 8'h94, 8'haa);
      chk({mass_erase_req, erase_active}, 32'h0);
      $display("mass done");
   endtask
   task automatic t_prog;
      cyc(5'h09, 8'hb2, 8'h01);
      cyc(5'h0a, 8'hb2, 8'h00);
      chk(sfr_rdata, 32'h0);
      cyc(5'h01, 8'hb2, 8'h01);
      cyc(5'h04, 8'h34, 8'h12);
      chk({flash_prog_req, flash_prog_addr, flash_prog_data}, 32'h011234ed);
      cyc(5'h04, 8'h00, 8'h40);
      chk(flash_prog_req, 32'h0);
      $display("program done");
   endtask
   initial begin
      repeat (5) @(posedge core_clk);
      resetn <= 1'h1;
      t_page;
      t_mass;
      t_prog;
      stop_test;
   end
   initial #100000 begin
      fails++;
      stop_test;
   end
endmodule
`default_nettype wire

/* fepc_flash_model.sv */
// Flash array model: busy while erasing
`timescale 1ns/1ps
`default_nettype none
module fepc_flash_model (input wire logic core_clk, erase_req, output wire logic flash_busy);
   logic [3:0] cnt = 4'h0;
   // Short busy span keeps the run brief
   always @(posedge core_clk) cnt <= erase_req ? 4'h8 : cnt - {3'h0, cnt != 4'h0};
   assign flash_busy = cnt != 4'h0;
endmodule
`default_nettype wire

/* fepc_map.vh */
// Register offsets, field positions, keys and timing for the flash erase/program controller
`ifndef FEPC_MAP_VH
`define FEPC_MAP_VH
`define FEPC_OFS_ERASE_TRIGGER   8'h94
`define FEPC_OFS_ENABLES         8'hb2
`define FEPC_OFS_PAGE_ADDR       8'hb7
`define FEPC_KEY_PAGE_ERASE      8'h55
`define FEPC_KEY_MASS_ERASE      8'haa
`define FEPC_BIT_MASS_EN         1
`define FEPC_BIT_PWE             0
`define FEPC_PGADR_MSB           7
`define FEPC_PGADR_LSB           1
`define FEPC_RST_BYTE            8'h00
`define FEPC_RST_PAGE            7'h00
`define FEPC_ERASE_DONE_MAX      8'hff
`endif
